// ### include/lbc_pkg.sv
// Package of constants for the local bus control and chip-select block
package lbc_pkg;
   localparam int unsigned ADDR_W        = 20;
   localparam logic [19:0] UPPER_RST_START = 20'h0_FFC00;
   localparam logic [19:0] UPPER_RST_END   = 20'h0_FFFFF;
   localparam logic [1:0]  STRAP_SAMPLE    = 2'h2;
   localparam logic [7:0]  NUM_ERR_TYPE  = 8'h10;
   localparam int unsigned MID_COUNT     = 4;
   localparam int unsigned PER_COUNT     = 5;

   typedef enum logic [1:0] {
      LBC_KIND_MEM_RD,
      LBC_KIND_MEM_WR,
      LBC_KIND_IO_RD,
      LBC_KIND_IO_WR
   } lbc_kind_type;
endpackage

// ### hdl/lbc_sync.sv
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module lbc_sync
#(
   parameter int unsigned WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             rst_n_i,
   // Data
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_reg <= '0;
         sync_o   <= '0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ### hdl/lbc_top.sv
// Local bus control: strobes, ready termination, hold hand-over, chip selects
// Contract
// R1: Write strobe asserted while write data is presented on the bus.
// R2: Asynchronous ready is synchronised before use.
// R3: Bus cycle ends only on a ready input, unless ready is ignored.
// R4: Synchronous ready is sampled as a level that ends the cycle.
// R5: Transceiver enable active only while data transfers.
// R6: Direction output shows whether the device sends or receives.
// R7: No hold grant while lock is active.
// R8: During reset lock pin is a weakly high input, not driven low.
// R9: Hold released only at an unlocked instruction boundary.
// R10: With hold granted, data bus and controls are floated.
// R11: Upper select active for memory or I/O within the upper range.
// R12: Upper range resets to 0FFC00H through 0FFFFFH, memory only.
// R13: Lower select only for memory within range; inactive until programmed.
// R14: Upper and lower select levels during reset choose emulation float mode.
// R15: Mid-range selects active for memory within the enabled block; code holds all four inactive in numerics mode.
// R16: Coprocessor request input noted; coprocessor select on coprocessor access.
// R17: Coprocessor error at numerics start raises interrupt type 16.
// R18: Peripheral selects active for memory or I/O within peripheral range.
// R19: Selects five and six may instead carry latched address bits 1 and 2.
// R20: During hold, strobe, enable, direction and lock outputs float.
// R21: Hold request and asynchronous ready pass a synchroniser first.
`timescale 1ns/1ns
`default_nettype none
module lbc_top
   import lbc_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   // Core cycle request
   input  wire logic              cyc_req_i,
   input  wire lbc_kind_type      cyc_kind_i,
   input  wire logic [19:0]       cyc_addr_i,
   input  wire logic              cyc_locked_i,
   input  wire logic              cyc_coproc_i,
   input  wire logic              insn_boundary_i,
   input  wire logic              numerics_start_i,
   output logic                   cyc_done_o,
   output logic                   numerics_irq_o,
   output logic [7:0]             numerics_irq_type_o,
   // Chip-select programming
   input  wire logic [19:0]       upper_start_i,
   input  wire logic              upper_prog_i,
   input  wire logic [19:0]       lower_end_i,
   input  wire logic              lower_prog_i,
   input  wire logic [19:0]       mcs_base_i,
   input  wire logic [19:0]       mcs_size_i,
   input  wire logic              mcs_en_i,
   input  wire logic [19:0]       pcs_base_i,
   input  wire logic [19:0]       pcs_size_i,
   input  wire logic              pcs_en_i,
   input  wire logic              pcs_addr_mode_i,
   input  wire logic              ignore_ready_i,
   input  wire logic              numerics_mode_i,
   // Bus pins
   input  wire logic              async_ready_in_i,
   input  wire logic              sync_ready_in_i,
   input  wire logic              hold_req_i,
   input  wire logic              coproc_transfer_request_i,
   input  wire logic              coproc_error_n_i,
   input  wire logic              upper_select_n_i,
   input  wire logic              lower_select_n_i,
   output logic                   write_strobe_n_o,
   output logic                   write_strobe_n_oe_o,
   output logic                   transceiver_enable_n_o,
   output logic                   transceiver_enable_n_oe_o,
   output logic                   buffer_direction_o,
   output logic                   buffer_direction_oe_o,
   output logic                   lock_n_o,
   output logic                   lock_n_oe_o,
   output logic                   data_oe_o,
   output logic                   hold_grant_o,
   output logic                   upper_select_n_o,
   output logic                   lower_select_n_o,
   output logic [MID_COUNT-1:0]   midrange_select_n_o,
   output logic [PER_COUNT-1:0]   periph_select_n_o,
   output logic                   periph_select5_or_addr1_o,
   output logic                   periph_select6_or_addr2_o,
   output logic                   coproc_select_n_o,
   output logic                   coproc_pending_o,
   output logic                   emulation_float_mode_o
);
   typedef enum logic [1:0] {
      LBC_IDLE,
      LBC_DATA,
      LBC_HOLD
   } lbc_state_type;

   lbc_state_type state_reg;
   lbc_state_type state_next;
   logic [6:0]    sync_q;
   logic          async_rdy_s;
   logic          sync_rdy_s;
   logic          hold_s;
   logic          creq_s, cerr_s, strap_up_s, strap_lo_s;
   logic          ready_w;
   logic          is_mem;
   logic          act;
   logic [19:0]   blk;
   logic [19:0]   addr_reg;
   lbc_kind_type  kind_reg;
   logic          locked_reg;
   logic [1:0]    strap_cnt_reg;
   logic [19:0]   upper_start_reg;
   logic          upper_io_reg;
   logic [19:0]   lower_end_reg;
   logic          lower_valid_reg;

   function automatic logic in_block(input logic [19:0] a, input logic [19:0] base,
                                     input logic [19:0] size);
      logic [20:0] top;
      top = {1'b0, base} + {1'b0, size};
      in_block = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
   endfunction

   // Pins pass two flops; low-active pins enter inverted so a reset flop reads idle
   lbc_sync #(.WIDTH(7)) u_sync
   (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .async_i   ({async_ready_in_i, sync_ready_in_i, hold_req_i, coproc_transfer_request_i,
                   !coproc_error_n_i, !upper_select_n_i, !lower_select_n_i}),
      .sync_o    (sync_q)
   ); // R21 R2

   assign async_rdy_s = sync_q[6];
   assign sync_rdy_s  = sync_q[5]; // R4
   assign hold_s      = sync_q[4];
   assign creq_s      = sync_q[3];
   assign cerr_s      = sync_q[2];
   assign strap_up_s  = sync_q[1];
   assign strap_lo_s  = sync_q[0];
   assign ready_w     = async_rdy_s || sync_rdy_s || ignore_ready_i; // R3
   assign is_mem      = (kind_reg == LBC_KIND_MEM_RD) || (kind_reg == LBC_KIND_MEM_WR);
   assign act         = state_reg == LBC_DATA && !(ready_w);
   assign blk         = mcs_size_i >> 2;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         LBC_IDLE:
         begin
            if (hold_s && insn_boundary_i && !cyc_locked_i && !cyc_req_i)
            begin
               state_next = LBC_HOLD; // R9 R7
            end
            else if (cyc_req_i)
            begin
               state_next = LBC_DATA;
            end
         end
         LBC_DATA:
         begin
            if (ready_w)
            begin
               state_next = LBC_IDLE; // R3
            end
         end
         LBC_HOLD:
         begin
            if (!hold_s)
            begin
               state_next = LBC_IDLE;
            end
         end
         default:
         begin
            state_next = LBC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= LBC_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Cycle capture
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         addr_reg   <= '0;
         kind_reg   <= LBC_KIND_MEM_RD;
         locked_reg <= 1'b0;
      end
      else if (state_reg == LBC_IDLE && state_next == LBC_DATA)
      begin
         addr_reg   <= cyc_addr_i;
         kind_reg   <= cyc_kind_i;
         locked_reg <= cyc_locked_i;
      end
   end

   // Chip-select range programming, reset defaults
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         upper_start_reg <= UPPER_RST_START; // R12
         upper_io_reg    <= 1'b0;
         lower_end_reg   <= '0;
         lower_valid_reg <= 1'b0; // R13
      end
      else
      begin
         if (upper_prog_i)
         begin
            upper_start_reg <= upper_start_i;
            upper_io_reg    <= 1'b1;
         end
         if (lower_prog_i)
         begin
            lower_end_reg   <= lower_end_i;
            lower_valid_reg <= 1'b1;
         end
      end
   end

   // Emulation float strap read emulation_float_mode the synchronisers show the pins after release
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         strap_cnt_reg          <= 2'h0;
         emulation_float_mode_o <= 1'b0;
      end
      else if (strap_cnt_reg <= STRAP_SAMPLE)
      begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == STRAP_SAMPLE)
         begin
            emulation_float_mode_o <= strap_up_s && strap_lo_s; // R14
         end
      end
   end

   // Bus control strobes and enables
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         write_strobe_n_o          <= 1'b1;
         write_strobe_n_oe_o       <= 1'b0;
         transceiver_enable_n_o    <= 1'b1;
         transceiver_enable_n_oe_o <= 1'b0;
         buffer_direction_o        <= 1'b0;
         buffer_direction_oe_o     <= 1'b0;
         lock_n_o                  <= 1'b1;
         lock_n_oe_o               <= 1'b0; // R8
         data_oe_o                 <= 1'b0;
         hold_grant_o              <= 1'b0;
         cyc_done_o                <= 1'b0;
      end
      else
      begin
         write_strobe_n_o          <= !(state_next == LBC_DATA && is_wr_next(state_reg));
         transceiver_enable_n_o    <= !(state_next == LBC_DATA); // R5
         buffer_direction_o        <= (state_next == LBC_DATA) && is_wr_next(state_reg); // R6
         lock_n_o                  <= !(state_next == LBC_DATA && lock_next(state_reg));
         write_strobe_n_oe_o       <= state_next != LBC_HOLD; // R20
         transceiver_enable_n_oe_o <= state_next != LBC_HOLD;
         buffer_direction_oe_o     <= state_next != LBC_HOLD;
         lock_n_oe_o               <= state_next != LBC_HOLD;
         data_oe_o                 <= (state_next == LBC_DATA) && is_wr_next(state_reg); // R1 R10
         hold_grant_o              <= state_next == LBC_HOLD; // R10 R7
         cyc_done_o                <= state_reg == LBC_DATA && ready_w;
      end
   end

   function automatic logic is_wr_next(input lbc_state_type s);
      lbc_kind_type k;
      k = (s == LBC_IDLE) ? cyc_kind_i : kind_reg;
      is_wr_next = (k == LBC_KIND_MEM_WR) || (k == LBC_KIND_IO_WR); // R1
   endfunction

   function automatic logic lock_next(input lbc_state_type s);
      lock_next = (s == LBC_IDLE) ? cyc_locked_i : locked_reg;
   endfunction

   // Chip-select decode during an active cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         upper_select_n_o          <= 1'b1;
         lower_select_n_o          <= 1'b1;
         midrange_select_n_o       <= '1;
         periph_select_n_o         <= '1;
         periph_select5_or_addr1_o <= 1'b1;
         periph_select6_or_addr2_o <= 1'b1;
         coproc_select_n_o         <= 1'b1;
      end
      else
      begin
         upper_select_n_o <= !(act && addr_reg >= upper_start_reg
                               && (is_mem || upper_io_reg)); // R11 R12
         lower_select_n_o <= !(act && is_mem && lower_valid_reg
                               && addr_reg <= lower_end_reg); // R13
         for (int i = 0; i < MID_COUNT; i++)
         begin
            midrange_select_n_o[i] <= !(act && is_mem && mcs_en_i && !numerics_mode_i
               && in_block(addr_reg, mcs_base_i + blk * 20'(i), blk)); // R15
         end
         for (int j = 0; j < PER_COUNT; j++)
         begin
            periph_select_n_o[j] <= !(act && pcs_en_i
               && in_block(addr_reg, pcs_base_i + pcs_size_i * 20'(j), pcs_size_i)); // R18
         end
         if (pcs_addr_mode_i)
         begin
            if (act)
            begin
               periph_select5_or_addr1_o <= addr_reg[1]; // R19
               periph_select6_or_addr2_o <= addr_reg[2];
            end
         end
         else
         begin
            periph_select5_or_addr1_o <= !(act && pcs_en_i
               && in_block(addr_reg, pcs_base_i + pcs_size_i * 20'd5, pcs_size_i)); // R19
            periph_select6_or_addr2_o <= !(act && pcs_en_i
               && in_block(addr_reg, pcs_base_i + pcs_size_i * 20'd6, pcs_size_i));
         end
         coproc_select_n_o <= !(act && numerics_mode_i && cyc_coproc_i); // R16
      end
   end

   // Numerics handshake: request flag and error interrupt
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         coproc_pending_o    <= 1'b0;
         numerics_irq_o      <= 1'b0;
         numerics_irq_type_o <= '0;
      end
      else
      begin
         coproc_pending_o    <= numerics_mode_i && creq_s; // R16
         numerics_irq_o      <= numerics_mode_i && numerics_start_i && cerr_s; // R17
         numerics_irq_type_o <= NUM_ERR_TYPE;
      end
   end
endmodule
`default_nettype wire

// ### verification/lbc_top_sva.sv
// Concurrent checks on the ports of the local bus control block
`timescale 1ns/1ns
`default_nettype none
module lbc_top_sva
   import lbc_pkg::*;
(
   // Clock and reset
   input wire logic         ref_clk_i,
   input wire logic         rst_n_i,
   // Core side
   input wire lbc_kind_type cyc_kind_i,
   input wire logic         cyc_locked_i,
   input wire logic         cyc_coproc_i,
   input wire logic         insn_boundary_i,
   input wire logic         numerics_start_i,
   input wire logic         ignore_ready_i,
   input wire logic         cyc_done_o,
   input wire logic         numerics_irq_o,
   input wire logic [7:0]   numerics_irq_type_o,
   // Pins
   input wire logic         async_ready_in_i,
   input wire logic         sync_ready_in_i,
   input wire logic         hold_req_i,
   input wire logic         coproc_error_n_i,
   input wire logic         write_strobe_n_o,
   input wire logic         write_strobe_n_oe_o,
   input wire logic         transceiver_enable_n_o,
   input wire logic         transceiver_enable_n_oe_o,
   input wire logic         buffer_direction_o,
   input wire logic         buffer_direction_oe_o,
   input wire logic         lock_n_o,
   input wire logic         lock_n_oe_o,
   input wire logic         data_oe_o,
   input wire logic         hold_grant_o,
   input wire logic         lower_select_n_o,
   input wire logic [3:0]   midrange_select_n_o,
   input wire logic         coproc_select_n_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic is_wr;
   logic is_mem;
   assign is_wr = (cyc_kind_i == LBC_KIND_MEM_WR) || (cyc_kind_i == LBC_KIND_IO_WR);
   assign is_mem = (cyc_kind_i == LBC_KIND_MEM_RD) || (cyc_kind_i == LBC_KIND_MEM_WR);
   write_strobe_a: assert property (!write_strobe_n_o |-> is_wr)
      else $error("write strobe on a read");
   dir_kind_a: assert property (!transceiver_enable_n_o |-> buffer_direction_o == is_wr)
      else $error("direction does not match transfer");
   end_release_a: assert property (cyc_done_o |-> transceiver_enable_n_o && write_strobe_n_o)
      else $error("strobes still active at cycle end");
   done_ready_a: assert property (cyc_done_o |->
      $past(sync_ready_in_i, 3) || $past(async_ready_in_i, 3) || $past(ignore_ready_i))
      else $error("cycle ended without ready");
   lower_mem_a: assert property (!lower_select_n_o |-> is_mem)
      else $error("lower select on io cycle");
   mid_mem_a: assert property (midrange_select_n_o != 4'hF |-> is_mem)
      else $error("mid-range select on io cycle");
   grant_boundary_a: assert property ($rose(hold_grant_o) |->
      $past(insn_boundary_i) && !$past(cyc_locked_i) && $past(hold_req_i, 3))
      else $error("hold granted off an unlocked boundary");
   grant_float_a: assert property (hold_grant_o |-> !write_strobe_n_oe_o
      && !transceiver_enable_n_oe_o && !buffer_direction_oe_o && !lock_n_oe_o && !data_oe_o)
      else $error("outputs driven during hold");
   lock_grant_a: assert property (lock_n_oe_o && !lock_n_o |=> !$rose(hold_grant_o))
      else $error("hold granted while locked");
   coproc_sel_a: assert property (!coproc_select_n_o |-> $past(cyc_coproc_i))
      else $error("coprocessor select without access");
   numerics_irq_a: assert property (numerics_irq_o |-> $past(numerics_start_i)
      && !$past(coproc_error_n_i, 3) && numerics_irq_type_o == NUM_ERR_TYPE)
      else $error("numerics interrupt wrong");
endmodule
bind lbc_top lbc_top_sva u_sva (.*);
`default_nettype wire

// ### verification/lbc_far_model.sv
// Model of memories and board straps facing the bus pins
`timescale 1ns/1ns
`default_nettype none
module lbc_far_model
(
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   // Controls from the bench
   input  wire logic       use_async_i,
   input  wire logic       mute_i,
   input  wire logic [3:0] delay_i,
   input  wire logic       strap_low_i,
   // Pins
   input  wire logic       transceiver_enable_n_i,
   input  wire logic       upper_select_n_i,
   input  wire logic       lower_select_n_i,
   output logic            async_ready_o,
   output logic            sync_ready_o,
   output logic            upper_pin_o,
   output logic            lower_pin_o
);
   logic [3:0] wait_reg;
   logic       armed_reg;
   // Board pulls both selects low to ask for float mode; lock pin is never driven
   assign upper_pin_o = strap_low_i ? 1'b0 : upper_select_n_i;
   assign lower_pin_o = strap_low_i ? 1'b0 : lower_select_n_i;
   // One ready pulse per cycle, after a chosen wait
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wait_reg <= 4'h0;
         armed_reg <= 1'b1;
         async_ready_o <= 1'b0;
         sync_ready_o <= 1'b0;
      end
      else
      begin
         async_ready_o <= 1'b0;
         sync_ready_o <= 1'b0;
         if (transceiver_enable_n_i)
         begin
            wait_reg <= 4'h0;
            armed_reg <= 1'b1;
         end
         else if (armed_reg && !mute_i)
         begin
            if (wait_reg == delay_i)
            begin
               armed_reg <= 1'b0;
               async_ready_o <= use_async_i;
               sync_ready_o <= !use_async_i;
            end
            else
               wait_reg <= wait_reg + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the local bus control block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import lbc_pkg::*;
   typedef struct packed
   {
      lbc_kind_type kind;
      logic [19:0]  addr;
      logic [10:0]  sel;
   } lbc_row_type;
   localparam lbc_row_type ROWS [14] = '{
      '{LBC_KIND_MEM_RD, 20'h0_FFC00, 11'h3FF}, '{LBC_KIND_MEM_WR, 20'h0_FFFFF, 11'h3FF},
      '{LBC_KIND_MEM_RD, 20'h0_FFBFF, 11'h7FF}, '{LBC_KIND_IO_RD, 20'h0_FFC00, 11'h7FF},
      '{LBC_KIND_MEM_RD, 20'h0_00100, 11'h7FF}, '{LBC_KIND_MEM_RD, 20'h0_21000, 11'h7BF},
      '{LBC_KIND_IO_WR, 20'h0_21000, 11'h7FF}, '{LBC_KIND_IO_WR, 20'h0_00480, 11'h7FD},
      '{LBC_KIND_MEM_RD, 20'h0_00600, 11'h7EF}, '{LBC_KIND_MEM_WR, 20'h0_0FFFF, 11'h5FF},
      '{LBC_KIND_MEM_RD, 20'h0_10000, 11'h7FF}, '{LBC_KIND_IO_RD, 20'h0_F0000, 11'h3FF},
      '{LBC_KIND_IO_RD, 20'h0_0FFFF, 11'h7FF}, '{LBC_KIND_MEM_RD, 20'h0_EFFFF, 11'h7FF}};
   logic ref_clk_i, rst_n_i, cyc_req_i, cyc_locked_i, cyc_coproc_i, insn_boundary_i;
   logic numerics_start_i, upper_prog_i, lower_prog_i, mcs_en_i, pcs_en_i, pcs_addr_mode_i;
   logic ignore_ready_i, numerics_mode_i, hold_req_i, coproc_transfer_request_i;
   logic coproc_error_n_i, use_async, mute, strap_low;
   logic [3:0] delay;
   logic [19:0] cyc_addr_i, upper_start_i, lower_end_i, mcs_base_i, mcs_size_i, pcs_base_i;
   logic [19:0] pcs_size_i;
   lbc_kind_type cyc_kind_i;
   wire logic async_ready_in_i, sync_ready_in_i, upper_select_n_i, lower_select_n_i;
   logic cyc_done_o, numerics_irq_o, write_strobe_n_o, write_strobe_n_oe_o, lock_n_o;
   logic transceiver_enable_n_o, transceiver_enable_n_oe_o, buffer_direction_o;
   logic buffer_direction_oe_o, lock_n_oe_o, data_oe_o, hold_grant_o, upper_select_n_o;
   logic lower_select_n_o, periph_select5_or_addr1_o, periph_select6_or_addr2_o;
   logic coproc_select_n_o, coproc_pending_o, emulation_float_mode_o;
   logic [7:0] numerics_irq_type_o;
   logic [3:0] midrange_select_n_o;
   logic [4:0] periph_select_n_o;
   int errors = 0;
   int n_compared = 0;
   lbc_top dut (.*);
   lbc_far_model u_far (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .use_async_i(use_async),
      .mute_i(mute), .delay_i(delay), .strap_low_i(strap_low),
      .transceiver_enable_n_i(transceiver_enable_n_o), .upper_select_n_i(upper_select_n_o),
      .lower_select_n_i(lower_select_n_o), .async_ready_o(async_ready_in_i),
      .sync_ready_o(sync_ready_in_i), .upper_pin_o(upper_select_n_i),
      .lower_pin_o(lower_select_n_i));
   always #50 ref_clk_i = ~ref_clk_i;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_done(output int lat);
      lat = 0;
      while (cyc_done_o !== 1'b1 && lat < 40)
      begin
         @(negedge ref_clk_i);
         lat++;
      end
   endtask
   task automatic bus_cycle(input lbc_kind_type k, input logic [19:0] a, input logic cp,
                            output logic [18:0] sel, output int lat);
      @(negedge ref_clk_i);
      cyc_kind_i = k;
      {cyc_addr_i, cyc_coproc_i, cyc_req_i} = {a, cp, 1'b1};
      @(negedge ref_clk_i);
      cyc_req_i = 1'b0;
      @(negedge ref_clk_i);
      sel = {data_oe_o, buffer_direction_o, transceiver_enable_n_o, lock_n_o,
             write_strobe_n_o, upper_select_n_o, lower_select_n_o, midrange_select_n_o,
             periph_select_n_o, periph_select6_or_addr2_o, periph_select5_or_addr1_o,
             coproc_select_n_o};
      wait_done(lat);
      repeat (3) @(negedge ref_clk_i);
   endtask
   task automatic do_reset(input logic strap);
      strap_low = strap;
      rst_n_i = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      check(lock_n_oe_o, 0);
      check({hold_grant_o, upper_select_n_o, lower_select_n_o}, 3'b011);
      rst_n_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      strap_low = 1'b0;
      check(emulation_float_mode_o, strap);
   endtask
   task automatic end_of_test;
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #2_000_000;
      errors++;
      end_of_test();
   end
   initial
   begin
      logic [18:0] sel;
      logic wr;
      int lat;
      int lat0;
      {ref_clk_i, cyc_req_i, cyc_locked_i, cyc_coproc_i, insn_boundary_i} = '0;
      {numerics_start_i, upper_prog_i, lower_prog_i, pcs_addr_mode_i, ignore_ready_i} = '0;
      {numerics_mode_i, hold_req_i, coproc_transfer_request_i, use_async, mute} = '0;
      {mcs_en_i, pcs_en_i, coproc_error_n_i, delay} = {3'b111, 4'h0};
      cyc_kind_i = LBC_KIND_MEM_RD;
      {cyc_addr_i, upper_start_i, lower_end_i} = {20'h0_0000, 20'h0_F0000, 20'h0_0FFFF};
      {mcs_base_i, mcs_size_i} = {20'h0_20000, 20'h0_04000};
      {pcs_base_i, pcs_size_i} = {20'h0_00400, 20'h0_00080};
      do_reset(1'b0);
      for (int i = 0; i < 14; i++)
      begin
         if (i == 9)
         begin
            {upper_prog_i, lower_prog_i} = 2'b11;
            @(negedge ref_clk_i);
            {upper_prog_i, lower_prog_i} = 2'b00;
         end
         bus_cycle(ROWS[i].kind, ROWS[i].addr, 1'b0, sel, lat);
         wr = ROWS[i].kind inside {LBC_KIND_MEM_WR, LBC_KIND_IO_WR};
         check(sel[13:3], ROWS[i].sel);
         check(sel[18:14], {wr, wr, 1'b0, 1'b1, !wr});
         check({sel[2:0], lat < 40}, 4'hF);
      end
      lat0 = lat;
      delay = 4'h6;
      bus_cycle(LBC_KIND_MEM_RD, 20'h0_10000, 1'b0, sel, lat);
      check(lat - lat0, 6);
      {use_async, delay} = {1'b1, 4'h0};
      bus_cycle(LBC_KIND_IO_WR, 20'h0_10000, 1'b0, sel, lat);
      check(lat, lat0);
      {use_async, mute} = 2'b01;
      bus_cycle(LBC_KIND_MEM_WR, 20'h0_10000, 1'b0, sel, lat);
      check(lat, 40);
      mute = 1'b0;
      wait_done(lat);
      check(lat < 40, 1);
      {mute, ignore_ready_i} = 2'b11;
      repeat (3) @(negedge ref_clk_i);
      bus_cycle(LBC_KIND_MEM_RD, 20'h0_10000, 1'b0, sel, lat);
      check(lat < 40, 1);
      {mute, ignore_ready_i, pcs_addr_mode_i} = 3'b001;
      bus_cycle(LBC_KIND_IO_RD, 20'h0_00484, 1'b0, sel, lat);
      check(sel[7:1], 7'b1110110);
      {cyc_locked_i, insn_boundary_i, hold_req_i} = 3'b111;
      bus_cycle(LBC_KIND_MEM_RD, 20'h0_10000, 1'b0, sel, lat);
      check({sel[15], lat < 40}, 2'b01);
      repeat (10) @(negedge ref_clk_i);
      check(hold_grant_o, 0);
      {cyc_locked_i, insn_boundary_i} = 2'b00;
      repeat (10) @(negedge ref_clk_i);
      check(hold_grant_o, 0);
      insn_boundary_i = 1'b1;
      for (int i = 0; i < 8 && hold_grant_o !== 1'b1; i++) @(negedge ref_clk_i);
      check(hold_grant_o, 1);
      check({write_strobe_n_oe_o, transceiver_enable_n_oe_o, buffer_direction_oe_o,
             lock_n_oe_o, data_oe_o, upper_select_n_o}, 6'h01);
      hold_req_i = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      check(hold_grant_o, 0);
      {numerics_mode_i, coproc_error_n_i} = 2'b10;
      repeat (3) @(negedge ref_clk_i);
      numerics_start_i = 1'b1;
      @(negedge ref_clk_i);
      numerics_start_i = 1'b0;
      check({numerics_irq_o, numerics_irq_type_o}, 9'h110);
      coproc_error_n_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      numerics_start_i = 1'b1;
      @(negedge ref_clk_i);
      numerics_start_i = 1'b0;
      check(numerics_irq_o, 0);
      coproc_transfer_request_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      check(coproc_pending_o, 1);
      bus_cycle(LBC_KIND_IO_WR, 20'h0_30000, 1'b1, sel, lat);
      check(sel[0], 0);
      {coproc_transfer_request_i, numerics_mode_i} = 2'b00;
      do_reset(1'b1);
      do_reset(1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
